/* design/cio_params.svh */
// Purpose: constants for the configurable io pin block
// Assumes: one 20 MHz clock, byte-wide configuration port
// Notes: mode index values address the twelve pin mode registers
`ifndef CIO_PARAMS_SVH
`define CIO_PARAMS_SVH
`define CIO_MODE_IDX_FIRST 8'h50
`define CIO_MODE_IDX_LAST 8'h5B
`define CIO_DATA_IDX_FIRST 8'h5C
`define CIO_DATA_IDX_LAST 8'h5E
`define CIO_ALT_IDX_FIRST 8'h2C
`define CIO_ALT_IDX_LAST 8'h2F
`define CIO_MODE_RESET 8'h00
`define CIO_DATA_RESET 8'h00
`define CIO_PIN_COUNT 24
`define CIO_GROUP_WIDTH 8
`define CIO_KEYBOARD_SERIAL_CLOCK_IN_PIN_HI 7
`define CIO_KEYBOARD_SERIAL_CLOCK_IN_PIN_LO 0
`endif

/* design/cio_pkg.sv */
// Purpose: types for the configurable io pin block
// Assumes: nothing beyond the params header
// Notes: function codes are two bits per pin per direction
package cio_pkg;
  // input function chosen when the pin is not driving
  typedef enum logic [1:0] {
    CIO_IN_PLAIN,
    CIO_IN_IRQ,
    CIO_IN_BUS,
    CIO_IN_KEY
  } cio_in_fn_e;
  // output function chosen when the pin drives
  typedef enum logic [1:0] {
    CIO_OUT_PLAIN,
    CIO_OUT_SELECT,
    CIO_OUT_BUS,
    CIO_OUT_SCAN
  } cio_out_fn_e;
  // per-pin configuration: direction, functions and a sub-select
  typedef struct packed {
    logic drive;
    cio_in_fn_e in_fn;
    cio_out_fn_e out_fn;
    logic [2:0] sub_sel;
  } cio_pin_cfg_s;
  // register access port: write and read strobes, index and data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cio_cfg_req_s;
  // one programmable select
  typedef struct packed {
    logic mem_space;
    logic wide;
    logic [1:0] qual;
    logic [1:0] trap;
    logic [7:0] start;
    logic [7:0] stop;
    logic [7:0] base;
  } cio_sel_cfg_s;
  // system bus cycle seen by the decoder
  typedef struct packed {
    logic active;
    logic mem;
    logic rd;
    logic wr;
    logic [19:0] addr;
  } cio_bus_s;
  typedef enum logic [1:0] {
    CIO_QUAL_ADDR,
    CIO_QUAL_READ,
    CIO_QUAL_WRITE,
    CIO_QUAL_RSVD
  } cio_qual_e;
  typedef enum {
    CIO_CYC_IDLE,
    CIO_CYC_RUN
  } cio_cyc_e;
endpackage

/* design/cio_pin_block.sv */
// Purpose: 24 configurable pins with routing, chip selects and irq steering
// Assumes: config port and bus cycle come from logic on clk
// Notes: pin inputs pass two flip-flops; outputs all registered
//
// Function
// - 24 pins, three groups of eight
// - four input and four output functions
// - plain output drives written data bit
// - plain input reads pin level
// - twelve mode registers at 50H..5BH
// - secondary battery warning passed to power unit
// - three chip selects on any group
// - each select decodes io or memory
// - each select sets 8 or 16 bit width
// - select qualified address, read or write
// - optional nmi on read, write or both
// - io mode compares A7..0, base A15..8
// - memory mode compares A15..8, base A19..16
// - alternate range linkable, set from alt_cfg and alt_link ports
// - seven pins per group steer to irq pairs
// - irq 0,1,3,9 used internally
// - high byte enable out, iocs16 memcs16 in
// - 16 bit cycle when wide input asserted
// - bus clock selectable as pin output
// - suspend drives all pins low
// - scan and sense line n on pin n
`timescale 1ns/1ps
`include "cio_params.svh"
module cio_pin_block #(
  parameter int PINS = `CIO_PIN_COUNT,
  parameter int NSEL = 3
) (
  input wire logic clk, // 20 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire cio_pkg::cio_cfg_req_s cfg_req, // indexed config access
  input wire cio_pkg::cio_sel_cfg_s [NSEL-1:0] sel_cfg, // chip select setup
  input wire cio_pkg::cio_sel_cfg_s alt_cfg, // alternate range setup
  input wire logic [1:0] alt_link, // 0 off, 1..3 select linked
  input wire cio_pkg::cio_bus_s bus, // current system bus cycle
  input wire logic byte_high_enable_in, // internal high byte enable
  input wire logic bus_clock_in, // internal bus clock level
  input wire logic [PINS-1:0] scan_drive, // keyboard scan lines
  input wire logic suspend, // system suspend state
  input wire logic [PINS-1:0] pin_in, // pad input levels
  output logic [PINS-1:0] pin_out, // pad output levels
  output logic [PINS-1:0] pin_oe, // pad output enables
  output logic [7:0] cfg_rdata, // config read data
  output logic [NSEL-1:0] chip_select_out, // selects zero..two, high active
  output logic wide_cycle, // run 16 bit bus cycle
  output logic select_nmi, // trap nmi request pulse
  output logic [15:0] irq_out, // steered irq lines
  output logic secondary_battery_warning_out, // to power management unit
  output logic [PINS-1:0] keyboard_sense_line, // keyboard return lines
  output logic keyboard_serial_clock_in, // keyboard clock from pin
  output logic keyboard_serial_data_in // keyboard data from pin
);
  import cio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration storage
  logic [7:0] mode_r [12];
  logic [7:0] data_r [3];
  logic [PINS-1:0] pin_s1_r;
  logic [PINS-1:0] pin_s2_r;
  cio_pin_cfg_s cfg [PINS];
  cio_cyc_e cyc_r;

  // a pin's field takes its high bits from one mode byte, its low bits from the byte two above
  function automatic cio_pin_cfg_s pin_cfg(input logic [7:0] hi_byte, input logic [7:0] lo_byte,
      input int b);
    cio_pin_cfg_s c;
    logic [3:0] f;
    c = '0;
    f = {hi_byte[(b%4)*2 +: 2], lo_byte[(b%4)*2 +: 2]};
    c.drive = f[3];
    c.in_fn = cio_in_fn_e'({f[2], f[1]});
    c.out_fn = cio_out_fn_e'({f[2], f[0]});
    c.sub_sel = 3'(b);
    return c;
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++) begin : g_cfg
      // bytes go in as arguments so the field follows every mode write
      logic [7:0] hi_byte;
      logic [7:0] lo_byte;
      assign hi_byte = mode_r[(gp / `CIO_GROUP_WIDTH) * 4 + (gp % `CIO_GROUP_WIDTH) / 4];
      assign lo_byte = mode_r[(gp / `CIO_GROUP_WIDTH) * 4 + 2 + (gp % `CIO_GROUP_WIDTH) / 4];
      assign cfg[gp] = pin_cfg(hi_byte, lo_byte, gp % `CIO_GROUP_WIDTH);
    end
  endgenerate

  // true for the twelve mode register indexes
  function automatic logic is_mode_idx(input logic [7:0] idx);
    return idx >= `CIO_MODE_IDX_FIRST && idx <= `CIO_MODE_IDX_LAST;
  endfunction

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 12; i++) begin
        mode_r[i] <= `CIO_MODE_RESET;
      end
      for (int i = 0; i < 3; i++) begin
        data_r[i] <= `CIO_DATA_RESET;
      end
    end else if (cfg_req.wr) begin
      // unmapped indexes match neither range and change nothing
      if (is_mode_idx(cfg_req.index)) begin
        mode_r[4'(cfg_req.index - `CIO_MODE_IDX_FIRST)] <= cfg_req.wdata;
      end
      if (cfg_req.index >= `CIO_DATA_IDX_FIRST && cfg_req.index <= `CIO_DATA_IDX_LAST) begin
        data_r[2'(cfg_req.index - `CIO_DATA_IDX_FIRST)] <= cfg_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser
  // only the second stage feeds logic; the first may be metastable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_req.rd) begin
      // a read of an unmapped index returns zero
      cfg_rdata <= 8'h00;
      if (is_mode_idx(cfg_req.index)) begin
        cfg_rdata <= mode_r[4'(cfg_req.index - `CIO_MODE_IDX_FIRST)];
      end
      for (int g = 0; g < 3; g++) begin
        if (cfg_req.index == `CIO_DATA_IDX_FIRST + 8'(g)) begin
          for (int b = 0; b < 8; b++) begin
            // inputs show the pad, outputs read back the written bit
            cfg_rdata[b] <= cfg[g*8+b].drive ? data_r[g][b] : pin_s2_r[g*8+b];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip select decode
  function automatic logic range_hit(input cio_sel_cfg_s c, input cio_bus_s b);
    logic [7:0] a;
    logic base_ok;
    if (c.mem_space) begin
      a = b.addr[15:8];
      base_ok = b.addr[19:16] == c.base[3:0];
    end else begin
      a = b.addr[7:0];
      base_ok = b.addr[15:8] == c.base;
    end
    return b.active && (b.mem == c.mem_space) && base_ok && a >= c.start && a <= c.stop;
  endfunction

  function automatic logic qual_ok(input logic [1:0] q, input cio_bus_s b);
    case (q)
      CIO_QUAL_ADDR: qual_ok = 1'b1;
      CIO_QUAL_READ: qual_ok = b.rd;
      CIO_QUAL_WRITE: qual_ok = b.wr;
      default: qual_ok = 1'b0;
    endcase
  endfunction

  logic [NSEL-1:0] hit;
  logic [NSEL-1:0] trap_hit;
  logic [NSEL-1:0] wide_hit;
  logic alt_hit;
  assign alt_hit = range_hit(alt_cfg, bus);
  generate
    for (gp = 0; gp < NSEL; gp++) begin : g_sel
      logic any;
      assign any = range_hit(sel_cfg[gp], bus) || (alt_hit && alt_link == 2'(gp + 1));
      assign hit[gp] = any && qual_ok(sel_cfg[gp].qual, bus);
      assign wide_hit[gp] = any && sel_cfg[gp].wide;
      assign trap_hit[gp] = any && ((sel_cfg[gp].trap[0] && bus.rd) || (sel_cfg[gp].trap[1] && bus.wr));
    end
  endgenerate

  // bus-size strobes from pins routed as wide-cycle inputs
  // strobes are active low; a released line idles high
  logic ext_wide;
  always_comb begin
    ext_wide = 1'b0;
    for (int p = 0; p < PINS; p++) begin
      if (!cfg[p].drive && cfg[p].in_fn == CIO_IN_BUS && cfg[p].sub_sel[0] == bus.mem) begin
        ext_wide = ext_wide | ~pin_s2_r[p];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_out <= '0;
      wide_cycle <= 1'b0;
    end else begin
      chip_select_out <= hit;
      wide_cycle <= bus.active && (ext_wide || |wide_hit);
    end
  end

  // nmi pulses at most once per bus cycle, from a trap hit on its first clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_r <= CIO_CYC_IDLE;
      select_nmi <= 1'b0;
    end else begin
      select_nmi <= 1'b0;
      case (cyc_r)
        CIO_CYC_IDLE: begin
          if (bus.active) begin
            cyc_r <= CIO_CYC_RUN;
            select_nmi <= |trap_hit;
          end
        end
        CIO_CYC_RUN: begin
          if (!bus.active) begin
            cyc_r <= CIO_CYC_IDLE;
          end
        end
        default: cyc_r <= CIO_CYC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input routing: irq steering, battery, keyboard
  localparam logic [3:0] PRI [7] = '{4'd15, 4'd14, 4'd13, 4'd12, 4'd11, 4'd10, 4'd9};
  localparam logic [3:0] SEC [7] = '{4'd7, 4'd6, 4'd5, 4'd4, 4'd3, 4'd0, 4'd1};
  logic [15:0] irq_nxt;
  logic batt_nxt;
  logic kclk_nxt;
  logic kdat_nxt;
  logic [PINS-1:0] sense_nxt;
  always_comb begin
    irq_nxt = '0;
    batt_nxt = 1'b0;
    kclk_nxt = 1'b1;
    kdat_nxt = 1'b1;
    sense_nxt = '1;
    for (int p = 0; p < PINS; p++) begin
      if (!cfg[p].drive) begin
        case (cfg[p].in_fn)
          CIO_IN_IRQ: begin
            // sub_sel 0..6 picks pair, bit from data reg chooses secondary except for sub_sel 5
            if (cfg[p].sub_sel < 3'd7) begin
              if (data_r[p/8][p%8] && cfg[p].sub_sel != 3'd5) begin
                irq_nxt[SEC[cfg[p].sub_sel]] = irq_nxt[SEC[cfg[p].sub_sel]] | pin_s2_r[p];
              end else begin
                irq_nxt[PRI[cfg[p].sub_sel]] = irq_nxt[PRI[cfg[p].sub_sel]] | pin_s2_r[p];
              end
            end else begin
              batt_nxt = batt_nxt | ~pin_s2_r[p];
            end
          end
          CIO_IN_KEY: begin
            sense_nxt[p] = pin_s2_r[p];
            if (p == `CIO_KEYBOARD_SERIAL_CLOCK_IN_PIN_HI || p == `CIO_KEYBOARD_SERIAL_CLOCK_IN_PIN_LO) begin
              kclk_nxt = pin_s2_r[p];
            end else if (p < 8) begin
              kdat_nxt = pin_s2_r[p];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // lines 0,1,3,9 belong to internal sources; no arbitration is applied
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= '0;
      secondary_battery_warning_out <= 1'b0;
      keyboard_sense_line <= '1;
      keyboard_serial_clock_in <= 1'b1;
      keyboard_serial_data_in <= 1'b1;
    end else begin
      irq_out <= irq_nxt;
      secondary_battery_warning_out <= batt_nxt;
      keyboard_sense_line <= sense_nxt;
      keyboard_serial_clock_in <= kclk_nxt;
      keyboard_serial_data_in <= kdat_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output routing
  logic [PINS-1:0] out_nxt;
  logic [PINS-1:0] oe_nxt;
  always_comb begin
    out_nxt = '0;
    oe_nxt = '0;
    for (int p = 0; p < PINS; p++) begin
      if (cfg[p].drive) begin
        oe_nxt[p] = 1'b1;
        case (cfg[p].out_fn)
          CIO_OUT_PLAIN: out_nxt[p] = data_r[p/8][p%8];
          CIO_OUT_SELECT: begin
            // a select number beyond NSEL drives low
            out_nxt[p] = cfg[p].sub_sel[1:0] < 2'(NSEL) ?
                         hit[cfg[p].sub_sel[1:0]] : 1'b0;
          end
          CIO_OUT_BUS: begin
            out_nxt[p] = cfg[p].sub_sel[0] ? bus_clock_in : byte_high_enable_in;
          end
          CIO_OUT_SCAN: begin
            // scan lines only ever pull low, else released
            out_nxt[p] = 1'b0;
            oe_nxt[p] = scan_drive[p];
          end
          default: out_nxt[p] = 1'b0;
        endcase
      end
      // suspend wins over every function, scan lines included
      if (suspend) begin
        out_nxt[p] = 1'b0;
        oe_nxt[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
    end
  end
endmodule

/* sim/cio_pin_block_monitor.sv */
// Purpose: port checker for the configurable io pin block
// Assumes: one clock, async active low reset
// Notes: bound to every cio_pin_block instance
`timescale 1ns/1ps
module cio_pin_block_monitor #(
  parameter int PINS = 24,
  parameter int NSEL = 3
) (
  input wire logic clk, // clock
  input wire logic reset_n, // reset, active low
  input wire cio_pkg::cio_cfg_req_s cfg_req, // config access
  input wire cio_pkg::cio_sel_cfg_s [NSEL-1:0] sel_cfg, // select setup
  input wire cio_pkg::cio_sel_cfg_s alt_cfg, // alternate range
  input wire logic [1:0] alt_link, // alternate link
  input wire cio_pkg::cio_bus_s bus, // bus cycle
  input wire logic suspend, // suspend state
  input wire logic [PINS-1:0] pin_out, // pad levels
  input wire logic [PINS-1:0] pin_oe, // pad enables
  input wire logic [7:0] cfg_rdata, // config read data
  input wire logic [NSEL-1:0] chip_select_out, // selects
  input wire logic wide_cycle, // 16 bit cycle
  input wire logic select_nmi // trap pulse
);
  import cio_pkg::*;
  //////////////////////////////////////////
  // range match of one select for the current cycle
  function automatic logic hit(cio_sel_cfg_s c, cio_bus_s b);
    logic [7:0] a;
    logic [7:0] hi;
    a = c.mem_space ? b.addr[15:8] : b.addr[7:0];
    hi = c.mem_space ? {4'h0, b.addr[19:16]} : b.addr[15:8];
    hit = b.active && (b.mem == c.mem_space) && a >= c.start && a <= c.stop
      && hi == (c.mem_space ? {4'h0, c.base[3:0]} : c.base)
      && (c.qual == 2'h0 || (c.qual == 2'h1 && b.rd) || (c.qual == 2'h2 && b.wr));
  endfunction
  // the linked range is qualified by select zero's own read or write setting
  cio_sel_cfg_s alt_q;
  always_comb begin
    alt_q = alt_cfg;
    alt_q.qual = sel_cfg[0].qual;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////
  suspend_low_a: assert property (suspend |=> pin_out == '0 && pin_oe == '1)
    else $error("pins not driven low in suspend");
  reset_idle_a: assert property ($rose(reset_n) |-> pin_oe == '0 && chip_select_out == '0)
    else $error("outputs active after reset");
  nmi_pulse_a: assert property (select_nmi |-> $past(bus.active) ##1 !select_nmi)
    else $error("trap pulse without cycle or too long");
  io_hit_a: assert property (hit(sel_cfg[0], bus) |=> chip_select_out[0])
    else $error("select zero missed its range");
  mem_hit_a: assert property (hit(sel_cfg[1], bus) |=> chip_select_out[1])
    else $error("select one missed its range");
  cs_miss_a: assert property (!hit(sel_cfg[0], bus) && !(alt_link == 2'h1 && hit(alt_q, bus))
    |=> !chip_select_out[0])
    else $error("select zero outside its range");
  alt_link_a: assert property (alt_link == 2'h1 && hit(alt_q, bus) |=> chip_select_out[0])
    else $error("linked range missed");
  wide_size_a: assert property (hit(sel_cfg[0], bus) && sel_cfg[0].wide |=> wide_cycle)
    else $error("wide select gave narrow cycle");
  bad_index_a: assert property (cfg_req.rd && (cfg_req.index < 8'h50 || cfg_req.index > 8'h5E)
    |=> cfg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  suspend_c: cover property (suspend);
  nmi_c: cover property (select_nmi);
  mem_c: cover property (chip_select_out[1]);
endmodule
bind cio_pin_block cio_pin_block_monitor #(.PINS(PINS), .NSEL(NSEL)) u_mon (
  .clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .sel_cfg(sel_cfg), .alt_cfg(alt_cfg),
  .alt_link(alt_link), .bus(bus), .suspend(suspend), .pin_out(pin_out), .pin_oe(pin_oe),
  .cfg_rdata(cfg_rdata), .chip_select_out(chip_select_out), .wide_cycle(wide_cycle),
  .select_nmi(select_nmi));

/* sim/cio_pad_model.sv */
// Purpose: pads and outside devices of the configurable io pins
// Assumes: every pad has a pull-up or an outside driver
// Notes: a released pad shows the outside level, never the last driven one
`timescale 1ns/1ps
module cio_pad_model (
  input wire logic [23:0] pin_out, // levels from block
  input wire logic [23:0] pin_oe, // enables from block
  input wire logic [23:0] ext_lvl, // outside drivers, idle pulled up
  output logic [23:0] pin_in // resolved pad level
);
  // driven pads follow the block, released ones the outside world
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

/* sim/test_configurable_io_pin_block.sv */
// Purpose: self-checking bench for the configurable io pin block
// Assumes: inputs change on the falling edge
// Notes: select setups are fixed, table rows drive all but the two wide-strobe bus cycles
`timescale 1ns/1ps
module test_configurable_io_pin_block;
  import cio_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  cio_cfg_req_s cfg_req = '0;
  cio_sel_cfg_s [2:0] sel_cfg;
  cio_sel_cfg_s alt_cfg;
  logic [1:0] alt_link = 2'h1;
  cio_bus_s bus = '0;
  logic suspend = 1'b0;
  logic [23:0] scan_drive = 24'h400000;
  logic [23:0] ext_lvl = 24'hFFFFFF;
  logic [23:0] pin_in, pin_out, pin_oe;
  logic [7:0] cfg_rdata;
  logic [2:0] cs;
  logic wide, nmi, batt;
  logic [15:0] irq;
  logic [23:0] sense;
  logic kclk, kdat;
  logic bhe_in = 1'b0;
  logic bclk_in = 1'b0;
  int errors = 0;
  int n_tests = 0;
  // row: sel[23:22] rd[21] hit[20] addr[19:0]
  logic [23:0] tab [11] = '{24'h300310, 24'h10031F, 24'h200320, 24'h20030F, 24'h100905,
    24'h752000, 24'h552FFF, 24'h653000, 24'h662000, 24'hB00780, 24'h800780};
  always #25 clk = ~clk;
  cio_pin_block #(.PINS(24), .NSEL(3)) dut (
    .clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .sel_cfg(sel_cfg), .alt_cfg(alt_cfg),
    .alt_link(alt_link), .bus(bus), .byte_high_enable_in(bhe_in), .bus_clock_in(bclk_in),
    .scan_drive(scan_drive), .suspend(suspend), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .cfg_rdata(cfg_rdata), .chip_select_out(cs), .wide_cycle(wide),
    .select_nmi(nmi), .irq_out(irq), .secondary_battery_warning_out(batt),
    .keyboard_sense_line(sense), .keyboard_serial_clock_in(kclk),
    .keyboard_serial_data_in(kdat));
  cio_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  //////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] dat);
    @(negedge clk);
    cfg_req = {1'b1, 1'b0, idx, dat};
    @(negedge clk);
    cfg_req = '0;
  endtask
  task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clk);
    cfg_req = {1'b0, 1'b1, idx, 8'h00};
    @(negedge clk);
    cfg_req = '0;
    chk({16'h0000, cfg_rdata}, {16'h0000, exp});
  endtask
  // one bus cycle, one idle cycle after it
  task automatic row(input logic [23:0] r);
    @(negedge clk);
    bus = {1'b1, r[23:22] == 2'h1, r[21], ~r[21], r[19:0]};
    @(negedge clk);
    chk({23'h0, cs[r[23:22]]}, {23'h0, r[20]});
    chk({23'h0, wide}, {23'h0, r[20] && r[23:22] == 2'h0});
    chk({23'h0, nmi}, {23'h0, r[20] && r[21] && r[23:22] == 2'h0});
    bus = '0;
  endtask
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  //////////////////////////////////////////
  initial begin
    sel_cfg[0] = {1'b0, 1'b1, 2'h0, 2'h1, 8'h10, 8'h1F, 8'h03};
    sel_cfg[1] = {1'b1, 1'b0, 2'h0, 2'h0, 8'h20, 8'h2F, 8'h05};
    sel_cfg[2] = {1'b0, 1'b0, 2'h1, 2'h0, 8'h00, 8'hFF, 8'h07};
    alt_cfg = {1'b0, 1'b1, 2'h0, 2'h0, 8'h00, 8'h0F, 8'h09};
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    chk(pin_oe, 24'h000000);
    cfg_rd(8'h50, 8'h00);
    for (int i = 0; i < 12; i++) begin
      cfg_wr(8'h50 + i[7:0], 8'h5A - i[7:0]);
      cfg_rd(8'h50 + i[7:0], 8'h5A - i[7:0]);
      cfg_wr(8'h50 + i[7:0], 8'h00);
    end
    cfg_wr(8'h4F, 8'hFF);
    cfg_rd(8'h4F, 8'h00);
    cfg_rd(8'h5F, 8'h00);
    // pin 0 and 23 plain out, 22 scan, 16 select zero, 7 battery warning
    cfg_wr(8'h50, 8'h02);
    cfg_wr(8'h59, 8'hB0);
    cfg_wr(8'h5B, 8'h10);
    cfg_wr(8'h58, 8'h02);
    cfg_wr(8'h5A, 8'h01);
    cfg_wr(8'h53, 8'h80);
    cfg_wr(8'h5C, 8'h01);
    cfg_wr(8'h5E, 8'h80);
    @(negedge clk);
    chk(pin_oe, 24'hC10001);
    chk(pin_out & 24'hFEFFFF, 24'h800001);
    cfg_wr(8'h5C, 8'h00);
    @(negedge clk);
    chk(pin_out & 24'hFEFFFF, 24'h800000);
    ext_lvl = 24'hFFFE7F;
    repeat (3) @(negedge clk);
    chk({23'h0, batt}, 24'h000001);
    cfg_rd(8'h5D, 8'hFE);
    foreach (tab[i]) row(tab[i]);
    // A0/A1 keyboard clock/data; B8,B9 irq, B10 iocs16, B11 sense, B12 bhe, B13 bus clock
    cfg_wr(8'h50, 8'h05);
    cfg_wr(8'h52, 8'h0A);
    cfg_wr(8'h54, 8'h50);
    cfg_wr(8'h56, 8'h8A);
    cfg_wr(8'h55, 8'h0F);
    cfg_wr(8'h5D, 8'h02);
    ext_lvl = 24'hFFF37C;
    bhe_in = 1'b1;
    repeat (3) @(negedge clk);
    chk({8'h00, irq}, 24'h008040);
    chk(sense, 24'hFFF7FC);
    chk({22'h0, kclk, kdat}, 24'h000000);
    chk({22'h0, pin_out[13:12]}, 24'h000001);
    chk({22'h0, pin_oe[13:12]}, 24'h000003);
    bus = {1'b1, 1'b0, 1'b0, 1'b1, 20'h00100};
    @(negedge clk);
    chk({23'h0, wide}, 24'h000001);
    bus = {1'b1, 1'b1, 1'b0, 1'b1, 20'h10100};
    @(negedge clk);
    chk({23'h0, wide}, 24'h000000);
    bus = '0;
    suspend = 1'b1;
    @(negedge clk);
    chk(pin_out, 24'h000000);
    chk(pin_oe, 24'hFFFFFF);
    suspend = 1'b0;
    test_done;
  end
  initial begin
    #2000000;
    errors++;
    test_done;
  end
endmodule
